// [verilog/vi_pkg.sv]
package vi_pkg;

   // -----------------------------------------------------------------
   // stream format
   // -----------------------------------------------------------------
   localparam int VI_BPS = 8;
   localparam int VI_SEQ = 3;
   localparam int VI_PAR = 1;
   localparam int VI_DATA_W = VI_BPS * VI_PAR;
   localparam logic [17:0] VI_SEQ_W = 18'h00003;

   // -----------------------------------------------------------------
   // start-up geometry, 640 x 480
   // -----------------------------------------------------------------
   localparam logic [15:0] VI_MAX_WIDTH = 16'h0280;
   localparam logic [15:0] VI_MAX_HEIGHT = 16'h01E0;

   // -----------------------------------------------------------------
   // packet types and control packet symbol positions
   // -----------------------------------------------------------------
   localparam logic [3:0] VI_TYPE_VIDEO = 4'h0;
   localparam logic [3:0] VI_TYPE_CTRL = 4'hF;
   localparam logic [3:0] VI_IDX_HEIGHT = 4'h4;
   localparam logic [3:0] VI_IDX_ILACE = 4'h8;
   localparam logic [3:0] VI_IDX_DONE = 4'h9;
   localparam int VI_ILACE_BIT = 3;
   localparam int VI_FIELD_BIT = 2;

   // -----------------------------------------------------------------
   // field types and build options
   // -----------------------------------------------------------------
   localparam logic FIELD_TYPE_EVEN = 1'b0;
   localparam logic FIELD_TYPE_ODD = 1'b1;
   localparam logic VI_INIT_FIELD = FIELD_TYPE_EVEN;
   localparam logic VI_PASS_THROUGH = 1'b0;
   localparam logic VI_CTRL_OVERRIDE = 1'b0;
   localparam logic VI_RUNTIME_CTRL = 1'b0;

   typedef enum logic [5:0] {
      VI_ST_HDR = 6'h01,
      VI_ST_CTRL = 6'h02,
      VI_ST_VIDEO = 6'h04,
      VI_ST_PASS = 6'h08,
      VI_ST_DROP = 6'h10,
      VI_ST_FLUSH = 6'h20
   } vi_state_t;

endpackage : vi_pkg

// [verilog/vi_interlacer.sv]
`timescale 1ns/100ps
module vi_interlacer import vi_pkg::*; #(
   parameter logic INITIAL_FIELD = VI_INIT_FIELD,
   parameter logic PASS_THROUGH = VI_PASS_THROUGH,
   parameter logic CTRL_OVERRIDE = VI_CTRL_OVERRIDE,
   parameter logic RUNTIME_CTRL = VI_RUNTIME_CTRL
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [VI_DATA_W-1:0] din_data,
   input wire logic din_sop,
   input wire logic din_eop,
   input wire logic din_valid,
   output logic din_ready,
   output logic [VI_DATA_W-1:0] dout_data,
   output logic dout_sop,
   output logic dout_eop,
   output logic dout_valid,
   input wire logic dout_ready,
   input wire logic rt_go,
   output logic rt_busy,
   output logic field_next
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   vi_state_t state;
   vi_state_t next_state;
   logic take;
   logic [3:0] nib;
   logic push_valid;
   logic [VI_DATA_W-1:0] push_data;
   logic push_sop;
   logic push_eop;
   logic [VI_DATA_W-1:0] pend_data;
   logic pend_sop;
   logic pend_eop;
   logic [VI_DATA_W-1:0] skid_data;
   logic skid_sop;
   logic skid_eop;
   logic skid_valid;
   logic next_skid_valid;
   logic out_free;
   logic [15:0] cur_w;
   logic [15:0] cur_h;
   logic [15:0] ctl_w;
   logic [15:0] ctl_h;
   logic [3:0] ctl_ilace;
   logic [3:0] ilace_nib;
   logic [3:0] idx;
   logic in_ilace;
   logic field;
   logic ctrl_field;
   logic res_chg;
   logic [17:0] samp;
   logic [15:0] line;
   logic [17:0] line_samps;
   logic samp_last;
   logic kept;
   logic go_ok;
   logic ctrl_apply;

   // -----------------------------------------------------------------
   // stream decode helpers
   // -----------------------------------------------------------------
   assign take = din_valid & din_ready;
   assign nib = din_data[3:0];
   // one line is width pixels times planes in sequence
   assign line_samps = 18'(18'(cur_w) * VI_SEQ_W);
   assign samp_last = (samp == line_samps - 18'h00001);
   // even field keeps even lines, lines past the height are spare
   assign kept = (line[0] == field) && (line < cur_h);
   assign go_ok = !RUNTIME_CTRL || rt_go;
   assign ilace_nib = (idx == VI_IDX_ILACE) ? nib : ctl_ilace;
   assign res_chg = (ctl_w != cur_w) || (ctl_h != cur_h);
   assign ctrl_apply = (state == VI_ST_CTRL) && take && din_eop && (idx >= VI_IDX_ILACE);

   // field for the next frame as set by a control packet
   always_comb begin
      if (CTRL_OVERRIDE && !ilace_nib[VI_ILACE_BIT]) begin
         ctrl_field = ilace_nib[VI_FIELD_BIT];
      end else if (res_chg) begin
         ctrl_field = INITIAL_FIELD;
      end else begin
         ctrl_field = field;
      end
   end

   // -----------------------------------------------------------------
   // packet state machine and push selection
   // -----------------------------------------------------------------
   // a progressive frame is delayed one kept word so eop can land on it
   always_comb begin
      next_state = state;
      push_valid = 1'b0;
      push_data = din_data;
      push_sop = din_sop;
      push_eop = din_eop;
      case (state)
         VI_ST_HDR: begin
            if (take && din_sop) begin
               if (nib == VI_TYPE_CTRL) begin
                  push_valid = 1'b1;
                  next_state = din_eop ? VI_ST_HDR : VI_ST_CTRL;
               end else if (nib == VI_TYPE_VIDEO && in_ilace) begin
                  push_valid = PASS_THROUGH;
                  next_state = din_eop ? VI_ST_HDR : (PASS_THROUGH ? VI_ST_PASS : VI_ST_DROP);
               end else if (nib == VI_TYPE_VIDEO) begin
                  next_state = din_eop ? VI_ST_FLUSH : VI_ST_VIDEO;
               end else begin
                  push_valid = 1'b1;
                  next_state = din_eop ? VI_ST_HDR : VI_ST_PASS;
               end
            end
         end
         VI_ST_CTRL: begin
            if (take) begin
               push_valid = 1'b1;
               if (idx == VI_IDX_ILACE && !nib[VI_ILACE_BIT]) begin
                  // progressive frame leaves as a field of the chosen type
                  push_data = {din_data[VI_DATA_W-1:4], 1'b1, ctrl_field, 2'b00};
               end
               next_state = din_eop ? VI_ST_HDR : VI_ST_CTRL;
            end
         end
         VI_ST_PASS: begin
            if (take) begin
               push_valid = 1'b1;
               next_state = din_eop ? VI_ST_HDR : VI_ST_PASS;
            end
         end
         VI_ST_DROP: begin
            next_state = (take && din_eop) ? VI_ST_HDR : VI_ST_DROP;
         end
         VI_ST_VIDEO: begin
            if (take) begin
               if (kept || din_eop) begin
                  push_valid = 1'b1;
                  push_data = pend_data;
                  push_sop = pend_sop;
                  push_eop = din_eop && !kept;
               end
               if (din_eop) begin
                  next_state = kept ? VI_ST_FLUSH : VI_ST_HDR;
               end
            end
         end
         VI_ST_FLUSH: begin
            push_data = pend_data;
            push_sop = pend_sop;
            push_eop = 1'b1;
            if (!skid_valid) begin
               push_valid = 1'b1;
               next_state = VI_ST_HDR;
            end
         end
         default: begin
            next_state = VI_ST_HDR;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= VI_ST_HDR;
      end else begin
         state <= next_state;
      end
   end

   // -----------------------------------------------------------------
   // held word of a progressive frame
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pend_data <= '0;
         pend_sop <= 1'b0;
         pend_eop <= 1'b0;
      end else if (state == VI_ST_HDR && take && nib == VI_TYPE_VIDEO && !in_ilace) begin
         pend_data <= din_data;
         pend_sop <= 1'b1;
         pend_eop <= 1'b0;
      end else if (state == VI_ST_VIDEO && take && kept) begin
         pend_data <= din_data;
         pend_sop <= 1'b0;
         pend_eop <= din_eop;
      end
   end

   // -----------------------------------------------------------------
   // sample, line and control symbol counters
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         samp <= '0;
         line <= '0;
         idx <= '0;
      end else if (state == VI_ST_HDR && take) begin
         samp <= '0;
         line <= '0;
         idx <= '0;
      end else if (state == VI_ST_VIDEO && take) begin
         if (samp_last) begin
            samp <= '0;
            line <= line + 16'h0001;
         end else begin
            samp <= samp + 18'h00001;
         end
      end else if (state == VI_ST_CTRL && take && idx != VI_IDX_DONE) begin
         idx <= idx + 4'h1;
      end
   end

   // width, height and interlace nibbles, most significant first
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctl_w <= VI_MAX_WIDTH;
         ctl_h <= VI_MAX_HEIGHT;
         ctl_ilace <= '0;
      end else if (state == VI_ST_CTRL && take) begin
         if (idx < VI_IDX_HEIGHT) begin
            ctl_w <= {ctl_w[11:0], nib};
         end else if (idx < VI_IDX_ILACE) begin
            ctl_h <= {ctl_h[11:0], nib};
         end else if (idx == VI_IDX_ILACE) begin
            ctl_ilace <= nib;
         end
      end
   end

   // -----------------------------------------------------------------
   // working geometry and field selection
   // -----------------------------------------------------------------
   // a truncated control packet is forwarded but changes nothing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cur_w <= VI_MAX_WIDTH;
         cur_h <= VI_MAX_HEIGHT;
         in_ilace <= 1'b0;
      end else if (ctrl_apply) begin
         cur_w <= ctl_w;
         cur_h <= ctl_h;
         in_ilace <= ilace_nib[VI_ILACE_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         field <= INITIAL_FIELD;
      end else if (ctrl_apply) begin
         field <= ctrl_field;
      end else if (state == VI_ST_VIDEO && take && din_eop && !CTRL_OVERRIDE) begin
         field <= ~field;
      end
   end

   // -----------------------------------------------------------------
   // two-entry output buffer: output register plus skid entry
   // -----------------------------------------------------------------
   assign out_free = !dout_valid || dout_ready;

   always_comb begin
      if (skid_valid) begin
         next_skid_valid = !out_free;
      end else begin
         next_skid_valid = push_valid && !out_free;
      end
   end

   // a push only happens while the skid entry is empty, so none is lost
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dout_valid <= 1'b0;
         dout_data <= '0;
         dout_sop <= 1'b0;
         dout_eop <= 1'b0;
      end else if (out_free) begin
         dout_valid <= skid_valid || push_valid;
         dout_data <= skid_valid ? skid_data : push_data;
         dout_sop <= skid_valid ? skid_sop : push_sop;
         dout_eop <= skid_valid ? skid_eop : push_eop;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         skid_valid <= 1'b0;
         skid_data <= '0;
         skid_sop <= 1'b0;
         skid_eop <= 1'b0;
      end else begin
         skid_valid <= next_skid_valid;
         if (push_valid && !out_free) begin
            skid_data <= push_data;
            skid_sop <= push_sop;
            skid_eop <= push_eop;
         end
      end
   end

   // -----------------------------------------------------------------
   // input back-pressure and status
   // -----------------------------------------------------------------
   // registered ready: stalls while the skid entry holds a word
   always_ff @(posedge core_clk) begin
      if (rst) begin
         din_ready <= 1'b0;
      end else begin
         din_ready <= !next_skid_valid && next_state != VI_ST_FLUSH
            && (next_state != VI_ST_HDR || go_ok);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rt_busy <= 1'b0;
         field_next <= INITIAL_FIELD;
      end else begin
         rt_busy <= next_state != VI_ST_HDR;
         field_next <= field;
      end
   end

endmodule : vi_interlacer

// [verification/vi_interlacer_monitor.sv]
`timescale 1ns/100ps
// ----
// port checker
// ----
module vi_interlacer_monitor import vi_pkg::*; #(
   parameter logic INITIAL_FIELD = VI_INIT_FIELD
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic din_valid,
   input wire logic din_ready,
   input wire logic din_sop,
   input wire logic din_eop,
   input wire logic [VI_DATA_W-1:0] dout_data,
   input wire logic dout_sop,
   input wire logic dout_eop,
   input wire logic dout_valid,
   input wire logic dout_ready,
   input wire logic rt_busy,
   input wire logic field_next
);
   logic out_open;
   logic tk;
   assign tk = din_valid && din_ready;
   // open output packet, so a stray word is caught at once
   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_open <= 1'b0;
      end else if (dout_valid && dout_ready) begin
         out_open <= !dout_eop;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_reset_field: assert property ($fell(rst) |-> field_next == INITIAL_FIELD)
      else $error("field type after reset wrong");
   a_reset_idle: assert property ($fell(rst) |-> !dout_valid && !din_ready && !rt_busy)
      else $error("not idle after reset");
   a_out_hold: assert property (dout_valid && !dout_ready |=>
      dout_valid && $stable(dout_data) && $stable(dout_sop) && $stable(dout_eop))
      else $error("output word moved while stalled");
   a_first_sop: assert property (dout_valid && !out_open |-> dout_sop)
      else $error("packet without start on output");
   a_eop_next: assert property (dout_valid && dout_ready && dout_eop |=>
      !dout_valid || dout_sop)
      else $error("word after end is not a start");
   a_rise_cause: assert property ($rose(dout_valid) |->
      $past(tk, 1) || $past(tk, 2) || $past(tk, 3))
      else $error("output word with no input behind it");
   a_busy_sop: assert property (tk && din_sop && !din_eop |=> rt_busy)
      else $error("busy missing inside packet");
   a_field_pkt: assert property ($changed(field_next) |-> $past(rt_busy, 2))
      else $error("field type changed between packets");
   c_stall: cover property (dout_valid && !dout_ready ##1 dout_valid && dout_ready);
   c_field: cover property ($changed(field_next));
   c_end: cover property (dout_valid && dout_ready && dout_eop);
endmodule : vi_interlacer_monitor

bind vi_interlacer vi_interlacer_monitor #(.INITIAL_FIELD(INITIAL_FIELD)) i_mon (
   .core_clk(core_clk), .rst(rst), .din_valid(din_valid), .din_ready(din_ready),
   .din_sop(din_sop), .din_eop(din_eop), .dout_data(dout_data), .dout_sop(dout_sop),
   .dout_eop(dout_eop), .dout_valid(dout_valid), .dout_ready(dout_ready),
   .rt_busy(rt_busy), .field_next(field_next));

// [verification/vi_sink_model.sv]
`timescale 1ns/100ps
// ----
// downstream sink, records video packets only
// ----
module vi_sink_model import vi_pkg::*; (
   input wire logic core_clk,
   input wire logic [VI_DATA_W-1:0] dout_data,
   input wire logic dout_sop,
   input wire logic dout_eop,
   input wire logic dout_valid,
   input wire logic stall,
   output logic dout_ready
);
   logic [9:0] got[$];
   logic in_vid = 1'b0;
   logic [2:0] beat = 3'h0;
   initial dout_ready = 1'b0;
   // ready drops half the time when stalling, to fill the skid
   always @(posedge core_clk) begin
      beat <= beat + 3'h1;
      dout_ready <= !(stall && beat[2]);
      if (dout_valid && dout_ready) begin
         // one sample per word, planes in sequence
         if (dout_sop) in_vid = (dout_data[3:0] == VI_TYPE_VIDEO);
         if (in_vid) got.push_back({dout_eop, dout_sop, dout_data});
      end
   end
endmodule : vi_sink_model

// [verification/tb_top.sv]
`timescale 1ns/100ps
module tb_top import vi_pkg::*;;
   logic core_clk = 1'b0, rst = 1'b1, rt_go = 1'b1, stall = 1'b0, sel = 1'b0;
   logic [VI_DATA_W-1:0] alt_data;
   logic alt_ready, alt_sop, alt_eop, alt_valid, alt_dready, alt_busy, alt_field;
   logic din_valid = 1'b0, din_sop = 1'b0, din_eop = 1'b0;
   logic [VI_DATA_W-1:0] din_data = 8'h00;
   logic [VI_DATA_W-1:0] dout_data;
   logic din_ready, dout_sop, dout_eop, dout_valid, dout_ready, rt_busy, field_next;
   logic [9:0] exp_q[$];
   int n_fail = 0, n_tests = 0;
   always #2.5 core_clk = !core_clk;
   vi_interlacer i_vi_interlacer (.core_clk(core_clk), .rst(rst), .din_data(din_data),
      .din_sop(din_sop), .din_eop(din_eop), .din_valid(din_valid && !sel),
      .din_ready(din_ready),
      .dout_data(dout_data), .dout_sop(dout_sop), .dout_eop(dout_eop),
      .dout_valid(dout_valid), .dout_ready(dout_ready), .rt_go(rt_go),
      .rt_busy(rt_busy), .field_next(field_next));
   vi_sink_model i_vi_sink_model (.core_clk(core_clk), .dout_data(dout_data),
      .dout_sop(dout_sop), .dout_eop(dout_eop), .dout_valid(dout_valid),
      .stall(stall), .dout_ready(dout_ready));
   // second build with every option on, fed only while sel is high
   vi_interlacer #(.PASS_THROUGH(1'b1), .CTRL_OVERRIDE(1'b1), .RUNTIME_CTRL(1'b1))
      i_vi_interlacer_alt (.core_clk(core_clk), .rst(rst), .din_data(din_data),
      .din_sop(din_sop), .din_eop(din_eop), .din_valid(din_valid && sel),
      .din_ready(alt_ready), .dout_data(alt_data), .dout_sop(alt_sop), .dout_eop(alt_eop),
      .dout_valid(alt_valid), .dout_ready(alt_dready), .rt_go(rt_go),
      .rt_busy(alt_busy), .field_next(alt_field));
   vi_sink_model i_vi_sink_model_alt (.core_clk(core_clk), .dout_data(alt_data),
      .dout_sop(alt_sop), .dout_eop(alt_eop), .dout_valid(alt_valid),
      .stall(stall), .dout_ready(alt_dready));
   // ----
   // helpers
   // ----
   task close_out;
      if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // word held from negedge until taken at a rising edge
   task put(input logic [7:0] d, input logic s, input logic e);
      int k;
      din_data = d;
      din_sop = s;
      din_eop = e;
      din_valid = 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while ((sel ? alt_ready : din_ready) !== 1'b1 && k < 5000);
      if ((sel ? alt_ready : din_ready) !== 1'b1) n_fail++; // word never taken
      @(negedge core_clk);
   endtask : put
   // control packet: width, height nibbles msb first, then interlace nibble
   task ctrl(input logic [15:0] w, input logic [15:0] h, input logic [3:0] il);
      logic [31:0] wh;
      wh = {w, h};
      put({4'h0, VI_TYPE_CTRL}, 1'b1, 1'b0);
      for (int i = 7; i >= 0; i--) put({4'h0, wh[i*4+:4]}, 1'b0, 1'b0);
      put({4'h0, il}, 1'b0, 1'b1);
      din_valid = 1'b0;
   endtask : ctrl
   // video frame; kept lines of the given parity below h go in the expected queue
   // odd of 2 expects every line below h, as pass-through sends them
   task frame(input int lines, input int wpl, input int h, input int odd, input bit drop);
      logic [7:0] d;
      if (!drop) exp_q.push_back({2'b01, 4'h0, VI_TYPE_VIDEO});
      put({4'h0, VI_TYPE_VIDEO}, 1'b1, 1'b0);
      for (int l = 0; l < lines; l++) begin
         for (int k = 0; k < wpl; k++) begin
            d = 8'(k + l * 37);
            put(d, 1'b0, l == lines - 1 && k == wpl - 1);
            if (!drop && l < h && (odd > 1 || l % 2 == odd)) exp_q.push_back({2'b00, d});
         end
      end
      din_valid = 1'b0;
      if (!drop) exp_q[exp_q.size()-1][9] = 1'b1;
   endtask : frame
   task drain;
      int k;
      logic [9:0] g[$];
      k = 0;
      while (k < 8000 && (sel ? i_vi_sink_model_alt.got.size()
         : i_vi_sink_model.got.size()) < exp_q.size()) begin
         @(negedge core_clk);
         k++;
      end
      repeat (20) @(negedge core_clk);
      if (sel) g = i_vi_sink_model_alt.got;
      else g = i_vi_sink_model.got;
      chk("word count", 16'(g.size()), 16'(exp_q.size()));
      foreach (exp_q[i])
         if (i < g.size())
            chk("out word", 16'(g[i]), 16'(exp_q[i]));
      i_vi_sink_model.got.delete();
      i_vi_sink_model_alt.got.delete();
      exp_q.delete();
   endtask : drain
   // ----
   // tests
   // ----
   initial begin
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      chk("field after reset", 16'(field_next), 16'(FIELD_TYPE_EVEN));
      // start-up width of 640 pixels, three samples each
      frame(2, 640 * VI_SEQ, 480, 0, 1'b0);
      drain();
      chk("field toggled", 16'(field_next), 16'(FIELD_TYPE_ODD));
      stall = 1'b1;
      ctrl(16'h0004, 16'h0004, 4'h0);
      frame(4, 4 * VI_SEQ, 4, 0, 1'b0);
      drain();
      chk("field odd next", 16'(field_next), 16'(FIELD_TYPE_ODD));
      stall = 1'b0;
      frame(4, 4 * VI_SEQ, 4, 1, 1'b0);
      drain();
      chk("field even next", 16'(field_next), 16'(FIELD_TYPE_EVEN));
      // interlaced input is discarded entirely
      ctrl(16'h0004, 16'h0004, 4'h8);
      frame(2, 4 * VI_SEQ, 2, 0, 1'b1);
      drain();
      // new height resets the field; lines past the height are dropped
      stall = 1'b1;
      ctrl(16'h0004, 16'h0006, 4'h0);
      frame(8, 4 * VI_SEQ, 6, 0, 1'b0);
      drain();
      // all options on: the control packet picks the field, no toggling, pass-through
      sel = 1'b1;
      chk("alt field after reset", 16'(alt_field), 16'(FIELD_TYPE_EVEN));
      ctrl(16'h0004, 16'h0004, 4'h4);
      frame(4, 4 * VI_SEQ, 4, 1, 1'b0);
      drain();
      chk("alt field held", 16'(alt_field), 16'(FIELD_TYPE_ODD));
      ctrl(16'h0004, 16'h0004, 4'h8);
      frame(2, 4 * VI_SEQ, 2, 2, 1'b0);
      drain();
      // go low holds off new packets only where run-time control is built in
      rt_go = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("alt ready with go low", 16'(alt_ready), 16'h0000);
      chk("ready ignores go", 16'(din_ready), 16'h0001);
      rt_go = 1'b1;
      repeat (3) @(negedge core_clk);
      chk("alt ready with go high", 16'(alt_ready), 16'h0001);
      close_out();
   end
   // watchdog, well beyond the few thousand cycles the tests need
   initial begin
      #300000;
      n_fail++;
      close_out();
   end
endmodule : tb_top
